// File: common/card_cmd_if.sv
// Purpose: Command and answer link between terminal and card.
// Assumes: One clock; a command is a one-cycle valid pulse.
// Notes:   Path or identifier in the data field arrives pre-resolved
//          as a 16-bit target identifier; dataLen 0 means no data.
`timescale 1ns/1ps
`default_nettype none

interface card_cmd_if
    import card_cmd_pkg::*;
(
    input wire logic clk_sys
);
    logic        cmdValid;     // Command strobe, one cycle.
    cmd_t        cmdCode;      // Which command.
    logic [7:0]  cmdP1;        // First parameter byte.
    logic [7:0]  cmdP2;        // Second parameter byte.
    logic [7:0]  dataLen;      // Data field length, zero when empty.
    logic [15:0] targetId;     // Resolved target file identifier.
    logic [7:0]  expectLen;    // Expected response length.
    logic [1:0]  cmdChannel;   // Logical channel the command runs on.
    logic        rspValid;     // Answer strobe, one cycle.
    logic [15:0] rspStatus;    // Status word.
    logic        rspHasData;   // One response byte present.
    logic [7:0]  rspData;      // Response byte.

    // Terminal end.
    modport host (
        output cmdValid, cmdCode, cmdP1, cmdP2, dataLen, targetId,
        output expectLen, cmdChannel,
        input  rspValid, rspStatus, rspHasData, rspData
    );
    // Card end.
    modport card (
        input  cmdValid, cmdCode, cmdP1, cmdP2, dataLen, targetId,
        input  expectLen, cmdChannel,
        output rspValid, rspStatus, rspHasData, rspData
    );
endinterface

`default_nettype wire

// File: common/card_cmd_map.svh
// Purpose: Offsets, field positions, codes and status words for the
//          card command interpreter and its terminal end.
// Assumes: Byte-wide parameter fields.
// Notes:   Definitions only.
`ifndef CARD_CMD_MAP_SVH
`define CARD_CMD_MAP_SVH

// =====================================================================
// Selection control codes for file deactivation and reactivation.
// =====================================================================
`define SEL_BY_FID       8'h00
`define SEL_PATH_MASTER  8'h08
`define SEL_PATH_CURDF   8'h09

// =====================================================================
// Authentication key reference layout.
// =====================================================================
`define KEY_SPECIFIC_BIT 7
`define KEY_RSV_MASK     8'h60
`define KEY_NUM_MASK     8'h1f
`define KEY_NUM_MIN      5'h01
`define KEY_NUM_MAX      5'h1f

// =====================================================================
// Channel management codes.
// =====================================================================
`define CHAN_OPEN        8'h00
`define CHAN_CLOSE       8'h80
`define CHAN_ASSIGN      8'h00
`define CHAN_MAX         8'h03
`define CHAN_COUNT       4

// =====================================================================
// Status words returned by the card.
// =====================================================================
`define SW_OK            16'h9000
`define SW_BAD_PARAM     16'h6a86
`define SW_DENIED        16'h6982
`define SW_NOT_ALLOWED   16'h6985
`define SW_NO_CHANNEL    16'h6a81
`define SW_NO_FILE       16'h6a82

// =====================================================================
// File table size and the identifier meaning "no current file".
// =====================================================================
`define FILE_COUNT       8
`define FILE_IDX_W       3
`define FILE_NONE        16'h0000

`endif

// File: common/card_cmd_pkg.sv
// Purpose: Types shared by the card end and the terminal end.
// Assumes: Constants come from card_cmd_map.svh.
// Notes:   Types only.
package card_cmd_pkg;

    // Commands carried over the link.
    typedef enum logic [2:0] {
        CMD_DEACTIVATE,
        CMD_ACTIVATE,
        CMD_AUTH,
        CMD_CHANNEL,
        CMD_OTHER
    } cmd_t;

    // Algorithm and key choice made for authentication.
    typedef enum logic [1:0] {
        KEY_IMPLIED,
        KEY_GLOBAL,
        KEY_SPECIFIC
    } key_sel_t;

endpackage

// File: core/card_cmd_engine.sv
// Functional notes
// RQ1: Deactivate marks file only if access granted.
// RQ2: Success makes the target the current file.
// RQ3: Failed deactivate keeps current files unchanged.
// RQ4: Failed reactivate keeps current files unchanged.
// RQ5: Deactivated file refuses all but select, reactivate.
// RQ6: Selection control has three legal codes.
// RQ7: P2 zero; empty all-zero means current file.
// RQ8: Reactivate clears mark only if access granted.
// RQ9: Terminal selects application before authenticating.
// RQ10: P1 zero uses application's implied algorithm.
// RQ11: Key byte: scope bit, zero bits, number.
// RQ12: Zero key byte uses application's implied key.
// RQ13: Card assigns open channel, never channel zero.
// RQ14: Channel zero stays open, close refused.
// RQ15: Closed channel number may be reused.
// RQ16: P1 zero opens, only b8 set closes.
// RQ17: P2 zero assigns; 1 to 3 close only.
// RQ18: Channel byte returned only when P1P2 zero.
// RQ19: Reserved parameters rejected, state untouched.
//
// Purpose: Card end: executes the file, authentication and channel
//          commands and answers one cycle after each command.
// Assumes: Target identifiers arrive resolved; a small file table of
//          fixed identifiers and access grants is given at ports.
// Notes:   Current file pointers are kept per card, not per channel.
`include "card_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module card_cmd_engine
    import card_cmd_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    // Link to the terminal.
    card_cmd_if.card                    link,
    // File table: identifiers and access grants per file.
    input  wire logic [16*`FILE_COUNT-1:0] fileIds,
    input  wire logic [`FILE_COUNT-1:0] deactAllowed,
    input  wire logic [`FILE_COUNT-1:0] actAllowed,
    input  wire logic [15:0]            currentDfIn,
    // Other operations on files, from the rest of the card.
    input  wire logic                   otherOpValid,
    input  wire logic [15:0]            otherOpId,
    output logic                        otherOpRefused,
    // State shown to the card.
    output logic [`FILE_COUNT-1:0]      fileDeactivated,
    output logic [15:0]                 currentEf,
    output logic [15:0]                 currentDf,
    output logic [`CHAN_COUNT-1:0]      channelOpen,
    output logic                        authStart,
    output key_sel_t                    authKeySel,
    output logic [4:0]                  authKeyNum
);
    // =================================================================
    // Declarations.
    // =================================================================
    logic                   paramBad;   // Reserved parameter coding.
    logic                   useCurrent; // Command targets current file.
    key_sel_t               keySel;     // Decoded key choice.
    logic [15:0]            lookupId;   // Identifier being looked up.
    logic                   hit;        // Identifier found in table.
    logic [`FILE_IDX_W-1:0] hitIdx;     // Index of the found file.
    logic                   freeFound;  // A channel is free to open.
    logic [1:0]             freeChan;   // Lowest free channel.
    logic [1:0]             closeChan;  // Channel named for close.

    logic [`FILE_COUNT-1:0] deact_r;
    logic [15:0]            curEf_r;
    logic [15:0]            curDf_r;
    logic [`CHAN_COUNT-1:0] chan_r;
    logic                   rspValid_r;
    logic [15:0]            rspStatus_r;
    logic                   rspHasData_r;
    logic [7:0]             rspData_r;
    logic                   authStart_r;
    key_sel_t               authKeySel_r;
    logic [4:0]             authKeyNum_r;

    param_check u_check (
        .cmdRaw     (link.cmdCode),
        .p1         (link.cmdP1),
        .p2         (link.cmdP2),
        .dataLen    (link.dataLen),
        .paramBad   (paramBad),
        .useCurrent (useCurrent),
        .keySel     (keySel)
    );

    // =================================================================
    // File lookup: current file or the named identifier.
    // =================================================================
    assign lookupId = useCurrent ? curEf_r : link.targetId; // RQ7
    always_comb begin
        hit    = 1'b0;
        hitIdx = '0;
        for (int i = 0; i < `FILE_COUNT; i++) begin
            if (!hit && (fileIds[16*i +: 16] == lookupId) &&
                (lookupId != `FILE_NONE)) begin
                hit    = 1'b1;
                hitIdx = `FILE_IDX_W'(i);
            end
        end
    end

    // Lowest free channel above zero; channel zero is never handed out.
    always_comb begin
        freeFound = 1'b0;
        freeChan  = 2'd0;
        for (int c = `CHAN_COUNT - 1; c >= 1; c--) begin
            if (!chan_r[c]) begin
                freeFound = 1'b1; // RQ13
                freeChan  = 2'(c);
            end
        end
    end
    assign closeChan = link.cmdP2[1:0];

    // =================================================================
    // Lifecycle flags: set or cleared only on granted, legal commands.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            deact_r <= '0;
        end else if (link.cmdValid && !paramBad && hit) begin
            if (link.cmdCode == CMD_DEACTIVATE &&
                deactAllowed[hitIdx]) begin
                deact_r[hitIdx] <= 1'b1; // RQ1
            end else if (link.cmdCode == CMD_ACTIVATE &&
                         actAllowed[hitIdx]) begin
                deact_r[hitIdx] <= 1'b0; // RQ8
            end
        end
    end

    // =================================================================
    // Current file pointers: EF moves only on success; DF loads currentDfIn while empty, else held.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            curEf_r <= `FILE_NONE;
            curDf_r <= `FILE_NONE;
        end else begin
            curDf_r <= curDf_r; // RQ3 RQ4
            if (curDf_r == `FILE_NONE) begin
                curDf_r <= currentDfIn;
            end
            if (link.cmdValid && !paramBad && hit &&
                ((link.cmdCode == CMD_DEACTIVATE && deactAllowed[hitIdx])
                 || (link.cmdCode == CMD_ACTIVATE && actAllowed[hitIdx])))
            begin
                curEf_r <= fileIds[16*hitIdx +: 16]; // RQ2
            end
        end
    end

    // =================================================================
    // Channel table: channel zero always open.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chan_r <= `CHAN_COUNT'(1);
        end else if (link.cmdValid && !paramBad &&
                     link.cmdCode == CMD_CHANNEL) begin
            if (link.cmdP1 == `CHAN_OPEN && freeFound) begin
                chan_r[freeChan] <= 1'b1; // RQ13
            end else if (link.cmdP1 == `CHAN_CLOSE &&
                         closeChan != 2'd0) begin
                chan_r[closeChan] <= 1'b0; // RQ15
            end
            chan_r[0] <= 1'b1; // RQ14
        end
    end

    // =================================================================
    // Authentication start: the compute engine sits outside.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            authStart_r  <= 1'b0;
            authKeySel_r <= KEY_IMPLIED;
            authKeyNum_r <= 5'h00;
        end else begin
            authStart_r <= link.cmdValid && !paramBad &&
                           link.cmdCode == CMD_AUTH;
            if (link.cmdValid && !paramBad && link.cmdCode == CMD_AUTH)
            begin
                authKeySel_r <= keySel; // RQ10 RQ12
                authKeyNum_r <= link.cmdP2[4:0]; // RQ11
            end
        end
    end

    // =================================================================
    // Answer: status word and optional single byte, one cycle later.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rspValid_r   <= 1'b0;
            rspStatus_r  <= `SW_OK;
            rspHasData_r <= 1'b0;
            rspData_r    <= 8'h00;
        end else begin
            rspValid_r <= link.cmdValid;
            if (link.cmdValid) begin
                rspHasData_r <= 1'b0;
                rspData_r    <= 8'h00;
                rspStatus_r  <= `SW_OK;
                if (paramBad) begin
                    rspStatus_r <= `SW_BAD_PARAM; // RQ19
                end else begin
                    unique case (link.cmdCode)
                        CMD_DEACTIVATE: begin
                            if (!hit) rspStatus_r <= `SW_NO_FILE;
                            else if (!deactAllowed[hitIdx])
                                rspStatus_r <= `SW_DENIED; // RQ1
                        end
                        CMD_ACTIVATE: begin
                            if (!hit) rspStatus_r <= `SW_NO_FILE;
                            else if (!actAllowed[hitIdx])
                                rspStatus_r <= `SW_DENIED; // RQ8
                        end
                        CMD_AUTH: begin
                            rspStatus_r <= `SW_OK;
                        end
                        CMD_CHANNEL: begin
                            if (link.cmdP1 == `CHAN_OPEN) begin
                                if (!freeFound) begin
                                    rspStatus_r <= `SW_NO_CHANNEL;
                                end else begin
                                    // Byte only for P1P2 zero. RQ18
                                    rspHasData_r <= 1'b1;
                                    rspData_r    <= {6'h00, freeChan};
                                end
                            end
                        end
                        CMD_OTHER: begin
                            rspStatus_r <= `SW_NOT_ALLOWED;
                        end
                    endcase
                end
            end
        end
    end

    // =================================================================
    // Guard for other operations on deactivated files.
    // =================================================================
    always_comb begin
        otherOpRefused = 1'b0;
        for (int i = 0; i < `FILE_COUNT; i++) begin
            if (otherOpValid && deact_r[i] &&
                fileIds[16*i +: 16] == otherOpId) begin
                otherOpRefused = 1'b1; // RQ5
            end
        end
    end

    assign link.rspValid   = rspValid_r;
    assign link.rspStatus  = rspStatus_r;
    assign link.rspHasData = rspHasData_r;
    assign link.rspData    = rspData_r;
    assign fileDeactivated = deact_r;
    assign currentEf       = curEf_r;
    assign currentDf       = curDf_r;
    assign channelOpen     = chan_r;
    assign authStart       = authStart_r;
    assign authKeySel      = authKeySel_r;
    assign authKeyNum      = authKeyNum_r;
endmodule

`default_nettype wire

// File: core/param_check.sv
// Purpose: Decodes parameter bytes of the command group.
// Assumes: Purely combinational, used by the card end.
// Notes:   Flags a parameter set as reserved when no coding fits.
`include "card_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module param_check
    import card_cmd_pkg::*;
(
    // Command fields.
    input  wire logic [2:0] cmdRaw,
    input  wire logic [7:0] p1,
    input  wire logic [7:0] p2,
    input  wire logic [7:0] dataLen,
    // Decode results.
    output logic            paramBad,
    output logic            useCurrent,
    output key_sel_t        keySel
);
    // Selection control is legal only in its three codings.
    function automatic logic selOk(input logic [7:0] v);
        selOk = (v == `SEL_BY_FID) || (v == `SEL_PATH_MASTER) ||
                (v == `SEL_PATH_CURDF);
    endfunction

    cmd_t cmd;
    assign cmd = cmd_t'(cmdRaw);

    // =================================================================
    // Parameter legality and interpretation.
    // =================================================================
    always_comb begin
        paramBad   = 1'b0;
        useCurrent = 1'b0;
        keySel     = KEY_IMPLIED;
        unique case (cmd)
            CMD_DEACTIVATE, CMD_ACTIVATE: begin
                // Only three selection codes and a zero P2. RQ6 RQ7
                paramBad   = !selOk(p1) || (p2 != 8'h00);
                useCurrent = (p1 == 8'h00) && (p2 == 8'h00) &&
                             (dataLen == 8'h00); // RQ7
            end
            CMD_AUTH: begin
                // P1 zero means the application's own algorithm. RQ10
                paramBad = (p1 != 8'h00) ||
                           ((p2 & `KEY_RSV_MASK) != 8'h00); // RQ11
                if (p2 == 8'h00) begin
                    keySel = KEY_IMPLIED; // RQ12
                end else if (p2[4:0] == 5'h00) begin
                    paramBad = 1'b1; // RQ11
                end else if (p2[`KEY_SPECIFIC_BIT]) begin
                    keySel = KEY_SPECIFIC; // RQ11
                end else begin
                    keySel = KEY_GLOBAL; // RQ11
                end
            end
            CMD_CHANNEL: begin
                // Open takes only P2 zero; close takes 1 to 3. RQ16 RQ17
                if (p1 == `CHAN_OPEN) begin
                    paramBad = (p2 != `CHAN_ASSIGN);
                end else if (p1 == `CHAN_CLOSE) begin
                    paramBad = (p2 == 8'h00) || (p2 > `CHAN_MAX);
                end else begin
                    paramBad = 1'b1;
                end
            end
            CMD_OTHER: begin
                paramBad = 1'b0;
            end
            default: begin
                paramBad = 1'b1;
            end
        endcase
    end
endmodule

`default_nettype wire

// File: core/term_cmd_issuer.sv
// Purpose: Terminal end: issues one command at a time and returns
//          the card's answer to its user.
// Assumes: The user holds a request until reqReady is seen.
// Notes:   A new command waits for the previous answer.
`include "card_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module term_cmd_issuer
    import card_cmd_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // User request.
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire cmd_t        reqCode,
    input  wire logic [7:0]  reqP1,
    input  wire logic [7:0]  reqP2,
    input  wire logic [7:0]  reqLen,
    input  wire logic [15:0] reqTarget,
    input  wire logic [7:0]  reqExpect,
    input  wire logic [1:0]  reqChannel,
    input  wire logic        appSelected,
    // User answer.
    output logic             ansValid,
    output logic [15:0]      ansStatus,
    output logic             ansHasData,
    output logic [7:0]       ansData,
    // Link to the card.
    card_cmd_if.host         link
);
    typedef enum logic {IDLE, WAIT} tstate_t;
    tstate_t     state_r;   // Waiting for an answer or not.
    logic        cmdValid_r;
    cmd_t        cmdCode_r;
    logic [7:0]  p1_r, p2_r, len_r, exp_r;
    logic [15:0] tgt_r;
    logic [1:0]  chan_r;
    logic        ansValid_r, ansHasData_r;
    logic [15:0] ansStatus_r;
    logic [7:0]  ansData_r;

    // Authentication is held back until an application is selected.
    assign reqReady = (state_r == IDLE) &&
                      (reqCode != CMD_AUTH || appSelected); // RQ9

    // =================================================================
    // Command launch and wait for the answer.
    // =================================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r    <= IDLE;
            cmdValid_r <= 1'b0;
            cmdCode_r  <= CMD_OTHER;
            p1_r <= 8'h00; p2_r <= 8'h00; len_r <= 8'h00;
            exp_r <= 8'h00; tgt_r <= 16'h0000; chan_r <= 2'd0;
        end else begin
            cmdValid_r <= 1'b0;
            unique case (state_r)
                IDLE: if (reqValid && reqReady) begin
                    cmdValid_r <= 1'b1;
                    cmdCode_r  <= reqCode;
                    p1_r  <= reqP1;
                    p2_r  <= reqP2;
                    len_r <= reqLen;
                    tgt_r <= reqTarget;
                    exp_r <= reqExpect;
                    chan_r <= reqChannel;
                    state_r <= WAIT;
                end
                WAIT: if (link.rspValid) state_r <= IDLE;
            endcase
        end
    end

    // Answer capture.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ansValid_r <= 1'b0; ansHasData_r <= 1'b0;
            ansStatus_r <= 16'h0000; ansData_r <= 8'h00;
        end else begin
            ansValid_r <= link.rspValid;
            if (link.rspValid) begin
                ansStatus_r  <= link.rspStatus;
                ansHasData_r <= link.rspHasData;
                ansData_r    <= link.rspData;
            end
        end
    end

    assign link.cmdValid   = cmdValid_r;
    assign link.cmdCode    = cmdCode_r;
    assign link.cmdP1      = p1_r;
    assign link.cmdP2      = p2_r;
    assign link.dataLen    = len_r;
    assign link.targetId   = tgt_r;
    assign link.expectLen  = exp_r;
    assign link.cmdChannel = chan_r;
    assign ansValid   = ansValid_r;
    assign ansStatus  = ansStatus_r;
    assign ansHasData = ansHasData_r;
    assign ansData    = ansData_r;
endmodule

`default_nettype wire

// File: dv/card_cmd_props.sv
// Purpose: Assertions on the command link between the two ends.
// Assumes: One clock and a synchronous active-low reset.
// Notes:   Takes the interface's signals as plain inputs.
`include "card_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module card_cmd_props import card_cmd_pkg::*; (
    input wire logic        clk_sys, resetn, cmdValid, rspValid, rspHasData,
    input wire cmd_t        cmdCode,
    input wire logic [7:0]  cmdP1, cmdP2, rspData,
    input wire logic [15:0] rspStatus);
    // Command kind strobes; sel marks a selection code outside the legal set.
    logic fc, au, ch, sel, bad;
    assign fc = cmdValid && cmdCode inside {CMD_DEACTIVATE, CMD_ACTIVATE};
    assign au = cmdValid && cmdCode == CMD_AUTH;
    assign ch = cmdValid && cmdCode == CMD_CHANNEL;
    assign sel = fc && |cmdP1 && cmdP1[7:1] != 7'h04;
    assign bad = rspStatus == `SW_BAD_PARAM;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_answer_next: assert property (cmdValid |=> rspValid) else $error("late");
    a_sel_code: assert property (sel |=> bad) else $error("sel code");
    a_p2_zero: assert property (fc && |cmdP2 |=> bad) else $error("p2");
    a_key_zero: assert property (au && |cmdP2[6:5] |=> bad)
        else $error("key bits");
    a_chan_op: assert property (ch && |cmdP1[6:0] |=> bad)
        else $error("chan op");
    a_keep_basic: assert property (ch && cmdP1[7] && ~|cmdP2 |=> bad)
        else $error("basic close");
    a_byte_only: assert property (ch && |{cmdP1, cmdP2} |=> !rspHasData)
        else $error("stray byte");
    a_not_basic: assert property (rspValid && rspHasData |->
        rspData inside {8'h01, 8'h02, 8'h03}) else $error("chan num");
endmodule
`default_nettype wire

// File: dv/card_file_auth_channel_cmds_tb.sv
// Purpose: Both ends joined; commands issued from the terminal user side.
// Assumes: Inputs change on the falling clock edge.
// Notes:   File F0 grants both access conditions, file F1 neither.
`include "card_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module card_file_auth_channel_cmds_tb import card_cmd_pkg::*;;
    localparam logic [15:0] F0 = 16'h1111, F1 = 16'h2222, OK = `SW_OK;
    localparam logic [15:0] BAD = `SW_BAD_PARAM, NO = `SW_DENIED;
    localparam cmd_t DEA = CMD_DEACTIVATE, ACT = CMD_ACTIVATE;
    logic clk_sys = 1'h0, resetn = 1'h0, reqValid = 1'h0, otherOpValid = 1'h0;
    logic appSelected = 1'h1;
    cmd_t reqCode = CMD_OTHER;
    logic [7:0] reqP1 = 8'h0, reqP2 = 8'h0, reqLen = 8'h0, ansData;
    logic [15:0] reqTarget = 16'h0, ansStatus, currentEf, currentDf;
    logic reqReady, ansValid, ansHasData, otherOpRefused;
    logic [7:0] fileDeactivated;
    logic [3:0] channelOpen;
    key_sel_t authKeySel;
    logic [4:0] authKeyNum;
    int err_count = 0, checks = 0, cyc = 0, i;
    card_cmd_if lnk (.clk_sys);
    term_cmd_issuer u_term_cmd_issuer (.clk_sys, .resetn, .reqValid,
        .reqReady, .reqCode, .reqP1, .reqP2, .reqLen, .reqTarget,
        .reqExpect(8'h10), .reqChannel(2'h0), .appSelected, .ansValid,
        .ansStatus, .ansHasData, .ansData, .link(lnk.host));
    card_cmd_engine u_card_cmd_engine (.clk_sys, .resetn, .link(lnk.card),
        .fileIds({96'h0, F1, F0}), .deactAllowed(8'h1), .actAllowed(8'h1),
        .currentDfIn(16'h7f10), .otherOpValid, .otherOpId(F0), .otherOpRefused,
        .fileDeactivated, .currentEf, .currentDf, .channelOpen, .authStart(),
        .authKeySel, .authKeyNum);
    card_cmd_props u_card_cmd_props (.clk_sys, .resetn, .cmdValid(lnk.cmdValid),
        .rspValid(lnk.rspValid), .rspHasData(lnk.rspHasData), .cmdCode(lnk.cmdCode),
        .cmdP1(lnk.cmdP1), .cmdP2(lnk.cmdP2), .rspData(lnk.rspData),
        .rspStatus(lnk.rspStatus));
    always #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Answer lands a fixed two cycles after the request is taken.
    task automatic go(input cmd_t c, input logic [7:0] p1, p2,
                      input logic [15:0] t, st, input logic [8:0] d = 9'h0);
        @(negedge clk_sys);
        reqCode = c;
        {reqP1, reqP2, reqTarget} = {p1, p2, t};
        reqLen = (t == 16'h0) ? 8'h0 : 8'h2;
        reqValid = 1'h1;
        @(negedge clk_sys);
        reqValid = 1'h0;
        repeat (2) @(negedge clk_sys);
        chk("ans", {ansValid, ansStatus}, {1'h1, st});
        chk("data", {ansHasData, ansData & {8{ansHasData}}}, d);
    endtask
    // A hang costs a mismatch and ends the run.
    always @(posedge clk_sys)
        if (++cyc == 2000) begin
            err_count++;
            final_report;
        end
    initial begin
        repeat (6) @(negedge clk_sys);
        resetn = 1'h1;
        go(DEA, 8'h00, 8'h00, F0, OK);
        chk("file", {fileDeactivated, currentEf}, {8'h1, F0});
        otherOpValid = 1'h1;
        #1 chk("refused", otherOpRefused, 1'h1);
        go(DEA, 8'h00, 8'h00, F1, NO);
        go(ACT, 8'h00, 8'h00, F1, NO);
        chk("cur", {currentEf, currentDf}, {F0, 16'h7f10});
        go(ACT, 8'h00, 8'h00, 16'h0, OK);
        chk("lcs", fileDeactivated, 8'h0);
        chk("refused", otherOpRefused, 1'h0);
        go(DEA, 8'h08, 8'h00, F0, OK);
        go(ACT, 8'h09, 8'h00, F0, OK);
        go(DEA, 8'h0a, 8'h00, F0, BAD);
        go(DEA, 8'h00, 8'h01, F0, BAD);
        chk("lcs", fileDeactivated, 8'h0);
        go(CMD_AUTH, 8'h00, 8'h00, F0, OK);
        chk("key", authKeySel, KEY_IMPLIED);
        appSelected = 1'h0;
        #1 chk("ready", reqReady, 1'h0);
        @(negedge clk_sys) appSelected = 1'h1;
        go(CMD_AUTH, 8'h00, 8'h85, F0, OK);
        chk("key", {authKeySel, authKeyNum}, {KEY_SPECIFIC, 5'h05});
        go(CMD_AUTH, 8'h00, 8'h41, F0, BAD);
        for (i = 1; i < 4; i++)
            go(CMD_CHANNEL, 8'h00, 8'h00, 16'h0, OK, {1'h1, i[7:0]});
        go(CMD_CHANNEL, 8'h00, 8'h00, 16'h0, `SW_NO_CHANNEL);
        go(CMD_CHANNEL, 8'h80, 8'h02, 16'h0, OK);
        go(CMD_CHANNEL, 8'h00, 8'h00, 16'h0, OK, 9'h102);
        go(CMD_CHANNEL, 8'h80, 8'h00, 16'h0, BAD);
        chk("open", channelOpen, 4'hf);
        go(CMD_CHANNEL, 8'h40, 8'h00, 16'h0, BAD);
        go(CMD_CHANNEL, 8'h00, 8'h01, 16'h0, BAD);
        final_report;
    end
endmodule
`default_nettype wire
